/* File: cep_unit.sv */
// Exception and interrupt acceptance unit with APB registers.
// Assumes pipeline strobes and request lines come from logic on pclk.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cep_unit (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction pipeline.
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] cur_pc,
   input wire logic [31:0] next_pc,
   input wire logic trap_exec,
   input wire logic [4:0] trap_vec,
   input wire logic exception_return_instr_exec,
   input wire logic ei_exec,
   input wire logic di_exec,
   // Request sources.
   input wire logic nmi_req,
   input wire logic [cep_pkg::NIRQ-1:0] irq_req,
   // Redirect and acknowledges.
   output logic redirect,
   output logic [31:0] redirect_pc,
   output logic nmi_ack,
   output logic [cep_pkg::NIRQ-1:0] irq_ack,
   output logic [31:0] psw_out
);
   // Status word and save registers.
   logic [31:0] psw_ff;
   logic [31:0] epc_ff;
   logic [31:0] ests_ff;
   logic [31:0] ecr_ff;
   // Hidden NMI save registers.
   logic [31:0] npc_ff;
   logic [31:0] nsts_ff;
   // Per-source control registers.
   logic [7:0] icr_ff [cep_pkg::NIRQ];
   // One bit per level now in service.
   logic [7:0] isr_ff;
   // Bus response registers.
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   // Redirect outputs.
   logic redirect_ff;
   logic [31:0] redirect_pc_ff;
   logic nmi_ack_ff;
   logic [cep_pkg::NIRQ-1:0] irq_ack_ff;
   // Arbitration results.
   cep_pkg::cep_ev_e ev;
   logic [3:0] cur_lvl;
   logic [3:0] win_lvl;
   logic [1:0] win_idx;
   logic win_vld;
   logic int_ok;
   logic ill_hit;
   logic exception_return_instr_go;
   // Bus strobes and read mux.
   logic acc;
   logic wr_go;
   logic [31:0] rd_data;
   logic rd_hit;

   // Outputs come straight from flip-flops.
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign redirect = redirect_ff;
   assign redirect_pc = redirect_pc_ff;
   assign nmi_ack = nmi_ack_ff;
   assign irq_ack = irq_ack_ff;
   assign psw_out = psw_ff;

   // Access is answered one cycle into the access phase.
   assign acc = psel && penable && !pready_ff;
   // Writes land at the edge where pready is seen high.
   assign wr_go = psel && penable && pready_ff && pwrite;

   // Illegal pattern on the instruction about to execute.
   assign ill_hit = instr_valid
      && (instr_word[10:5] == cep_pkg::ILL_OP)
      && (instr_word[26:23] >= cep_pkg::ILL_SUB_MIN);

   // Lowest set in-service bit is the level being served.
   always_comb begin
      cur_lvl = 4'h8;
      for (int i = 7; i >= 0; i--) begin
         if (isr_ff[i]) begin
            cur_lvl = 4'(i);
         end
      end
   end

   // Pick the unmasked request of best level; low index on ties.
   always_comb begin
      win_lvl = 4'h8;
      win_idx = 2'h0;
      win_vld = 1'b0;
      for (int i = cep_pkg::NIRQ - 1; i >= 0; i--) begin
         if (irq_req[i] && !icr_ff[i][cep_pkg::ICR_MK] &&
             ({1'b0, icr_ff[i][2:0]} <= win_lvl)) begin
            win_lvl = {1'b0, icr_ff[i][2:0]};
            win_idx = 2'(i);
            win_vld = 1'b1;
         end
      end
   end

   // Maskable accepted only when enabled, outside NMI service,
   // and strictly above the level in service.
   assign int_ok = win_vld && !psw_ff[cep_pkg::PSW_ID]
      && !psw_ff[cep_pkg::PSW_NP]
      && (win_lvl < cur_lvl);

   // Fixed priority among simultaneous events.
   always_comb begin
      if (nmi_req && !psw_ff[cep_pkg::PSW_NP]) begin
         ev = cep_pkg::EV_NMI;
      end else if (int_ok) begin
         ev = cep_pkg::EV_INT;
      end else if (instr_valid && trap_exec) begin
         ev = cep_pkg::EV_TRAP;
      end else if (ill_hit) begin
         ev = cep_pkg::EV_ILL;
      end else begin
         ev = cep_pkg::EV_NONE;
      end
   end

   // A return executes only when no event takes the cycle.
   assign exception_return_instr_go = instr_valid && exception_return_instr_exec &&
      (ev == cep_pkg::EV_NONE);

   // Status word: events first, then return, bus, then EI/DI.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psw_ff <= cep_pkg::PSW_RST;
      end else begin
         case (ev)
            cep_pkg::EV_NMI: begin
               psw_ff[cep_pkg::PSW_NP] <= 1'b1;
               psw_ff[cep_pkg::PSW_ID] <= 1'b1;
            end
            cep_pkg::EV_INT: begin
               psw_ff[cep_pkg::PSW_ID] <= 1'b1;
            end
            cep_pkg::EV_TRAP, cep_pkg::EV_ILL: begin
               psw_ff[cep_pkg::PSW_EP] <= 1'b1;
               psw_ff[cep_pkg::PSW_ID] <= 1'b1;
            end
            default: begin
               if (exception_return_instr_go) begin
                  // NMI service returns through its own copy.
                  psw_ff <= psw_ff[cep_pkg::PSW_NP] ? nsts_ff :
                     ests_ff;
               end else if (wr_go && paddr == cep_pkg::OFF_PSW) begin
                  psw_ff <= {24'h0, pwdata[7:0]};
               end else if (instr_valid && di_exec) begin
                  psw_ff[cep_pkg::PSW_ID] <= 1'b1;
               end else if (instr_valid && ei_exec) begin
                  psw_ff[cep_pkg::PSW_ID] <= 1'b0;
               end
            end
         endcase
      end
   end

   // Save registers take return PC and status on acceptance.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         epc_ff <= 32'h0;
         ests_ff <= 32'h0;
      end else if (ev == cep_pkg::EV_INT) begin
         epc_ff <= cur_pc;
         ests_ff <= psw_ff;
      end else if (ev == cep_pkg::EV_TRAP || ev == cep_pkg::EV_ILL) begin
         epc_ff <= next_pc;
         ests_ff <= psw_ff;
      end else if (wr_go && paddr == cep_pkg::OFF_EPC) begin
         epc_ff <= pwdata;
      end else if (wr_go && paddr == cep_pkg::OFF_ESTS) begin
         ests_ff <= {24'h0, pwdata[7:0]};
      end
   end

   // NMI keeps its own save pair so it never clobbers the other.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         npc_ff <= 32'h0;
         nsts_ff <= 32'h0;
      end else if (ev == cep_pkg::EV_NMI) begin
         npc_ff <= cur_pc;
         nsts_ff <= psw_ff;
      end
   end

   // Cause register: low half ordinary, high half NMI.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ecr_ff <= 32'h0;
      end else begin
         case (ev)
            cep_pkg::EV_NMI: ecr_ff[31:16] <= cep_pkg::CC_NMI;
            cep_pkg::EV_INT: ecr_ff[15:0] <= cep_pkg::CC_INT_BASE +
               {10'h0, win_idx, 4'h0};
            cep_pkg::EV_TRAP: ecr_ff[15:0] <= cep_pkg::CC_TRAP_BASE +
               {11'h0, trap_vec};
            cep_pkg::EV_ILL: ecr_ff[15:0] <= cep_pkg::CC_ILL;
            default: ecr_ff <= ecr_ff;
         endcase
      end
   end

   // Redirect pulse and target for the fetch unit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         redirect_ff <= 1'b0;
         redirect_pc_ff <= 32'h0;
      end else begin
         redirect_ff <= (ev != cep_pkg::EV_NONE) || exception_return_instr_go;
         case (ev)
            cep_pkg::EV_NMI: redirect_pc_ff <= cep_pkg::HND_NMI;
            cep_pkg::EV_INT: redirect_pc_ff <= cep_pkg::HND_INT_BASE +
               {26'h0, win_idx, 4'h0};
            cep_pkg::EV_TRAP: redirect_pc_ff <= trap_vec[4] ?
               cep_pkg::HND_TRAP_HI : cep_pkg::HND_TRAP_LO;
            cep_pkg::EV_ILL: redirect_pc_ff <= cep_pkg::HND_ILL;
            default: begin
               if (exception_return_instr_go) begin
                  redirect_pc_ff <= psw_ff[cep_pkg::PSW_NP] ? npc_ff :
                     epc_ff;
               end
            end
         endcase
      end
   end

   // Acknowledge pulses tell the source its request was taken.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_ack_ff <= 1'b0;
         irq_ack_ff <= '0;
      end else begin
         nmi_ack_ff <= (ev == cep_pkg::EV_NMI);
         // Only the winning source sees its ack bit for one cycle.
         irq_ack_ff <= '0;
         if (ev == cep_pkg::EV_INT) begin
            irq_ack_ff[win_idx] <= 1'b1;
         end
      end
   end

   // In-service levels: set on acceptance, cleared by a return
   // from maskable service so pending ones may follow.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isr_ff <= 8'h00;
      end else if (ev == cep_pkg::EV_INT) begin
         isr_ff[win_lvl[2:0]] <= 1'b1;
      end else if (exception_return_instr_go && !psw_ff[cep_pkg::PSW_NP] &&
                   !psw_ff[cep_pkg::PSW_EP] && cur_lvl[3] == 1'b0) begin
         isr_ff[cur_lvl[2:0]] <= 1'b0;
      end
   end

   // One control register per source, masked at level 7 on reset.
   for (genvar g = 0; g < cep_pkg::NIRQ; g++) begin : g_icr
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            icr_ff[g] <= cep_pkg::ICR_RST;
         end else if (wr_go &&
                      paddr == cep_pkg::OFF_ICR0 + 12'(g * 4)) begin
            icr_ff[g] <= {1'b0, pwdata[6], 3'h0, pwdata[2:0]};
         end
      end
   end

   // Read mux; unmapped offsets answer with an error.
   always_comb begin
      rd_data = 32'h0;
      rd_hit = 1'b1;
      case (paddr)
         cep_pkg::OFF_PSW: rd_data = psw_ff;
         cep_pkg::OFF_EPC: rd_data = epc_ff;
         cep_pkg::OFF_ESTS: rd_data = ests_ff;
         cep_pkg::OFF_ECR: rd_data = ecr_ff;
         default: begin
            rd_hit = 1'b0;
            for (int i = 0; i < cep_pkg::NIRQ; i++) begin
               if (paddr == cep_pkg::OFF_ICR0 + 12'(i * 4)) begin
                  rd_data = {24'h0, icr_ff[i]};
                  rd_hit = 1'b1;
               end
            end
         end
      endcase
   end

   // APB response: one wait state, then data and error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= acc;
         pslverr_ff <= acc && !rd_hit;
         prdata_ff <= (acc && !pwrite) ? rd_data : 32'h0;
      end
   end

   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_trap_take;
      (instr_valid && trap_exec && !nmi_req && !int_ok)
         |-> ev == cep_pkg::EV_TRAP;
   endproperty
   a_trap_take: assert property (p_trap_take)
      else $error("trap not taken");

   property p_trap_save;
      (ev == cep_pkg::EV_TRAP) |=> epc_ff == $past(next_pc)
         && ests_ff == $past(psw_ff);
   endproperty
   a_trap_save: assert property (p_trap_save)
      else $error("trap save wrong");

   property p_trap_hi;
      (ev == cep_pkg::EV_TRAP && trap_vec[4]) |=> redirect_ff
         && redirect_pc_ff == cep_pkg::HND_TRAP_HI;
   endproperty
   a_trap_hi: assert property (p_trap_hi)
      else $error("trap handler wrong");

   property p_ill;
      (ev == cep_pkg::EV_ILL) |=> ecr_ff[15:0] == cep_pkg::CC_ILL
         && redirect_pc_ff == cep_pkg::HND_ILL && psw_ff[6:5] == 2'h3;
   endproperty
   a_ill: assert property (p_ill)
      else $error("illegal trap entry wrong");

   property p_ill_dec;
      (ev == cep_pkg::EV_ILL) |-> instr_word[10:5] == 6'h3F
         && instr_word[26:23] > 4'h2;
   endproperty
   a_ill_dec: assert property (p_ill_dec)
      else $error("illegal decode wrong");

   property p_exception_return_instr;
      (exception_return_instr_go && !psw_ff[cep_pkg::PSW_NP]) |=>
         psw_ff == $past(ests_ff) && redirect_pc_ff == $past(epc_ff);
   endproperty
   a_exception_return_instr: assert property (p_exception_return_instr)
      else $error("return restore wrong");

   property p_int_gate;
      (ev == cep_pkg::EV_INT) |-> !psw_ff[cep_pkg::PSW_NP]
         && win_lvl < cur_lvl ##1 psw_ff[cep_pkg::PSW_ID] && irq_ack_ff != 0;
   endproperty
   a_int_gate: assert property (p_int_gate)
      else $error("maskable accepted wrongly");

   property p_nmi_first;
      (nmi_req && !psw_ff[cep_pkg::PSW_NP]) |=> nmi_ack_ff
         && redirect_pc_ff == cep_pkg::HND_NMI;
   endproperty
   a_nmi_first: assert property (p_nmi_first)
      else $error("NMI not first");

   c_trap: cover property (ev == cep_pkg::EV_TRAP ##[1:20] exception_return_instr_go);
   c_nest: cover property (ev == cep_pkg::EV_INT ##[1:20]
      ev == cep_pkg::EV_INT);
   c_ill: cover property (ev == cep_pkg::EV_ILL);
endmodule : cep_unit
`default_nettype wire

/* File: cep_pkg.sv */
// Constants shared by the exception and interrupt acceptance unit.
// Assumes one clock domain and a 12-bit APB byte address.
package cep_pkg;
   // Number of maskable request sources.
   localparam int NIRQ = 4;
   // Register byte offsets.
   localparam logic [11:0] OFF_PSW = 12'h000;
   localparam logic [11:0] OFF_EPC = 12'h004;
   localparam logic [11:0] OFF_ESTS = 12'h008;
   localparam logic [11:0] OFF_ECR = 12'h00C;
   localparam logic [11:0] OFF_ICR0 = 12'h010;
   // Status word bit positions.
   localparam int PSW_NP = 7;
   localparam int PSW_EP = 6;
   localparam int PSW_ID = 5;
   // Control register fields.
   localparam int ICR_MK = 6;
   localparam int ICR_PR_LSB = 0;
   // Reset values.
   localparam logic [31:0] PSW_RST = 32'h0000_0020;
   localparam logic [7:0] ICR_RST = 8'h47;
   // Handler addresses.
   localparam logic [31:0] HND_TRAP_LO = 32'h0000_0040;
   localparam logic [31:0] HND_TRAP_HI = 32'h0000_0050;
   localparam logic [31:0] HND_ILL = 32'h0000_0060;
   localparam logic [31:0] HND_NMI = 32'h0000_0010;
   localparam logic [31:0] HND_INT_BASE = 32'h0000_0080;
   // Cause codes.
   localparam logic [15:0] CC_TRAP_BASE = 16'h0040;
   localparam logic [15:0] CC_ILL = 16'h0060;
   localparam logic [15:0] CC_NMI = 16'h0010;
   localparam logic [15:0] CC_INT_BASE = 16'h0080;
   // Illegal opcode pattern.
   localparam logic [5:0] ILL_OP = 6'h3F;
   localparam logic [3:0] ILL_SUB_MIN = 4'h3;
   // Event taken in a cycle, one-hot.
   typedef enum logic [4:0] {
      EV_NONE = 5'h01,
      EV_NMI = 5'h02,
      EV_INT = 5'h04,
      EV_TRAP = 5'h08,
      EV_ILL = 5'h10
   } cep_ev_e;
endpackage : cep_pkg

/* File: cep_src_model.sv */
// Model of the interrupt request sources beside the acceptance unit.
// Assumes acks are one-cycle pulses on pclk and raise strobes come from tb.
`timescale 1ns/1ps
`default_nettype none
module cep_src_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // One-cycle commands from the bench.
   input wire logic nmi_raise,
   input wire logic [cep_pkg::NIRQ-1:0] irq_raise,
   // Acknowledges from the unit.
   input wire logic nmi_ack,
   input wire logic [cep_pkg::NIRQ-1:0] irq_ack,
   // Request levels towards the unit.
   output logic nmi_req,
   output logic [cep_pkg::NIRQ-1:0] irq_req
);
   // Held request levels.
   logic nmi_ff;
   logic [cep_pkg::NIRQ-1:0] irq_ff;

   // A request stays up until its own ack, so a pending one is never lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_ff <= 1'b0;
         irq_ff <= '0;
      end else begin
         nmi_ff <= (nmi_ff & ~nmi_ack) | nmi_raise;
         irq_ff <= (irq_ff & ~irq_ack) | irq_raise;
      end
   end

   // The levels leave the model straight from the registers.
   assign nmi_req = nmi_ff;
   assign irq_req = irq_ff;
endmodule : cep_src_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the exception and interrupt acceptance unit.
// Assumes cep_pkg, cep_unit and cep_src_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Design and model connections.
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, instr_word, cur_pc, next_pc;
   logic [31:0] redirect_pc, psw_out, pc, q;
   logic instr_valid, trap_exec, exception_return_instr_exec, ei_exec, di_exec, redirect;
   logic [4:0] trap_vec, acks;
   logic nmi_req, nmi_raise, nmi_ack, e;
   logic [cep_pkg::NIRQ-1:0] irq_req, irq_raise, irq_ack;
   int errors, n_checks, cyc;

   cep_unit dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
      .instr_word(instr_word), .cur_pc(cur_pc), .next_pc(next_pc),
      .trap_exec(trap_exec), .trap_vec(trap_vec), .exception_return_instr_exec(exception_return_instr_exec),
      .ei_exec(ei_exec), .di_exec(di_exec), .nmi_req(nmi_req),
      .irq_req(irq_req), .redirect(redirect), .redirect_pc(redirect_pc),
      .nmi_ack(nmi_ack), .irq_ack(irq_ack), .psw_out(psw_out)
   );
   cep_src_model src (
      .pclk(pclk), .presetn(presetn), .nmi_raise(nmi_raise),
      .irq_raise(irq_raise), .nmi_ack(nmi_ack), .irq_ack(irq_ack),
      .nmi_req(nmi_req), .irq_req(irq_req)
   );

   // Free-running 10 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Sticky record of acks, cleared by the sequence after each window's compare.
   always @(negedge pclk) acks = acks | {irq_ack, nmi_ack};

   // Cuts a hang short well above the expected run length.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Values read right after the edge are those sampled at it.
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One instruction in execute; k is 1 return, 2 enable, 3 disable.
   task automatic issue(input logic [31:0] w, input logic t,
                        input logic [4:0] v, input int k);
      @(posedge pclk);
      pc = $urandom() & 32'hFFFF_FFFC;
      instr_valid <= 1'b1;
      instr_word <= w;
      trap_exec <= t;
      trap_vec <= v;
      exception_return_instr_exec <= (k == 1);
      ei_exec <= (k == 2);
      di_exec <= (k == 3);
      cur_pc <= pc - 32'h4;
      next_pc <= pc;
      @(posedge pclk);
      instr_valid <= 1'b0;
      trap_exec <= 1'b0;
      exception_return_instr_exec <= 1'b0;
      ei_exec <= 1'b0;
      di_exec <= 1'b0;
      @(negedge pclk);
   endtask : issue

   // One-cycle raise strobes to the source model.
   task automatic raise(input logic n, input logic [3:0] m);
      @(posedge pclk);
      nmi_raise <= n;
      irq_raise <= m;
      @(posedge pclk);
      nmi_raise <= 1'b0;
      irq_raise <= 4'h0;
   endtask : raise

   // Waits a fixed window, compares the ack record, then clears it.
   task automatic win(input logic [4:0] exp);
      repeat (10) @(negedge pclk);
      chk({27'h0, acks}, {27'h0, exp});
      acks = 5'h00;
   endtask : win

   // Bench expectation of the illegal opcode pattern.
   function automatic logic is_ill(input logic [31:0] w);
      return (w[10:5] == 6'h3F) && (w[26:23] >= 4'h3);
   endfunction : is_ill

   // Main sequence.
   initial begin
      logic [31:0] ps, w, tp;
      logic [4:0] v;
      void'($urandom(32'h8fb2));
      {presetn, psel, penable, pwrite, instr_valid, trap_exec} = 6'h00;
      {exception_return_instr_exec, ei_exec, di_exec, nmi_raise} = 4'h0;
      {paddr, pwdata, instr_word, cur_pc, next_pc} = '0;
      {trap_vec, irq_raise, acks, errors, n_checks, cyc} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(psw_out, 32'h20);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'h010 + 12'(4 * i), 32'h0);
         chk(q, 32'h47);
      end
      apb(1'b0, 12'hFFC, 32'h0);
      chk({31'h0, e}, 32'h1);
      // Traps, with corner vectors first and random ones after.
      for (int i = 0; i < 12; i++) begin
         v = (i < 4) ? 5'(i[1] * 16 + i[0] * 15) : 5'($urandom_range(31));
         ps = $urandom() & 32'h3F;
         apb(1'b1, 12'h000, ps);
         issue(32'h0, 1'b1, v, 0);
         tp = pc;
         chk({31'h0, redirect}, 32'h1);
         chk(redirect_pc, v[4] ? 32'h50 : 32'h40);
         chk(psw_out, ps | 32'h60);
         apb(1'b0, 12'h004, 32'h0);
         chk(q, tp);
         apb(1'b0, 12'h008, 32'h0);
         chk(q, ps);
         apb(1'b0, 12'h00C, 32'h0);
         chk({16'h0, q[15:0]}, 32'h40 + 32'(v));
         issue(32'h0, 1'b0, 5'h0, 1);
         chk(redirect_pc, tp);
         chk(psw_out, ps);
      end
      // Every sub-opcode value, then near misses of the opcode field.
      for (int i = 0; i < 22; i++) begin
         w = $urandom();
         w[10:5] = (i < 16) ? 6'h3F : 6'h3F ^ 6'(1 << (i % 6));
         w[26:23] = 4'(i);
         ps = $urandom() & 32'h3F;
         apb(1'b1, 12'h000, ps);
         issue(w, 1'b0, 5'h0, 0);
         tp = pc;
         chk({31'h0, redirect}, {31'h0, is_ill(w)});
         if (is_ill(w)) begin
            chk(redirect_pc, 32'h60);
            chk(psw_out, ps | 32'h60);
            apb(1'b0, 12'h00C, 32'h0);
            chk({16'h0, q[15:0]}, 32'h60);
            apb(1'b0, 12'h004, 32'h0);
            chk(q, tp);
            issue(32'h0, 1'b0, 5'h0, 1);
         end else begin
            chk(psw_out, ps);
         end
      end
      // A trap beats an illegal word in the same instruction.
      issue(32'h01C0_07E0, 1'b1, 5'h05, 0);
      tp = pc;
      apb(1'b0, 12'h00C, 32'h0);
      chk({16'h0, q[15:0]}, 32'h45);
      // The handler clears the active flag, then sets it again.
      apb(1'b1, 12'h000, 32'h20);
      apb(1'b1, 12'h000, 32'h60);
      issue(32'h0, 1'b0, 5'h0, 1);
      chk(redirect_pc, tp);
      chk(psw_out, ps);
      // Masked at reset, then blocked by the disable flag, then taken.
      apb(1'b1, 12'h000, 32'h0);
      raise(1'b0, 4'h1);
      acks = 5'h00;
      win(5'h00);
      issue(32'h0, 1'b0, 5'h0, 3);
      apb(1'b1, 12'h010, 32'h03);
      win(5'h00);
      issue(32'h0, 1'b0, 5'h0, 2);
      win(5'h02);
      chk({31'h0, psw_out[5]}, 32'h1);
      chk(redirect_pc, 32'h80);
      // The handler saves its return pair before it re-enables.
      apb(1'b0, 12'h004, 32'h0);
      tp = q;
      apb(1'b0, 12'h008, 32'h0);
      ps = q;
      // Nesting: only a strictly higher level preempts level 3.
      apb(1'b1, 12'h014, 32'h05);
      apb(1'b1, 12'h018, 32'h03);
      apb(1'b1, 12'h01C, 32'h01);
      raise(1'b0, 4'h6);
      issue(32'h0, 1'b0, 5'h0, 2);
      win(5'h00);
      raise(1'b0, 4'h8);
      win(5'h10);
      issue(32'h0, 1'b0, 5'h0, 1);
      issue(32'h0, 1'b0, 5'h0, 2);
      win(5'h00);
      // Restore the saved pair with acceptance blocked, then return.
      issue(32'h0, 1'b0, 5'h0, 3);
      apb(1'b1, 12'h004, tp);
      apb(1'b1, 12'h008, ps);
      issue(32'h0, 1'b0, 5'h0, 1);
      chk(redirect_pc, tp);
      chk(psw_out, ps);
      issue(32'h0, 1'b0, 5'h0, 2);
      win(5'h08);
      issue(32'h0, 1'b0, 5'h0, 1);
      issue(32'h0, 1'b0, 5'h0, 2);
      win(5'h04);
      issue(32'h0, 1'b0, 5'h0, 1);
      // NMI wins over a maskable request and holds it until return.
      apb(1'b1, 12'h000, 32'h0);
      raise(1'b1, 4'h1);
      win(5'h01);
      chk(redirect_pc, 32'h10);
      issue(32'h0, 1'b0, 5'h0, 1);
      issue(32'h0, 1'b0, 5'h0, 2);
      win(5'h02);
      // A reset in mid-service discards all state and masks again.
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(psw_out, 32'h20);
      chk(redirect_pc, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(q, 32'h47);
      stop_test();
   end
endmodule : tb
`default_nettype wire
